// file: logic/sfs_pkg.sv
package sfs_pkg;

	// Timing figures and the clock rate they are counted at.
	localparam int unsigned CLK_MHZ         = 250;
	localparam int unsigned LONG_WINDOW_MS  = 200;
	localparam int unsigned RESET_DELAY_US  = 2000;
	localparam int unsigned SHORT_FILTER_US = 4000;

	localparam int unsigned LONG_WINDOW_CYCLES  = LONG_WINDOW_MS * 1000 * CLK_MHZ;
	localparam int unsigned RESET_DELAY_CYCLES  = RESET_DELAY_US * CLK_MHZ;
	localparam int unsigned SHORT_FILTER_CYCLES = SHORT_FILTER_US * CLK_MHZ;

	// Blanking of the second regulator undervoltage flag after its enable changes.
	localparam logic [15:0] SECOND_SETTLE_CYCLES = 16'h00FF;

	// Undervoltage events that force fail-safe mode.
	localparam logic [2:0] UV_FAILSAFE_COUNT = 3'h4;

	// Register indices on the plain register port.
	localparam logic [3:0] REG_CTRL_MODE   = 4'h0;
	localparam logic [3:0] REG_SUPPLY_CTRL = 4'h1;
	localparam logic [3:0] REG_HS_CTRL     = 4'h2;
	localparam logic [3:0] REG_STATUS_A    = 4'h3;
	localparam logic [3:0] REG_STATUS_B    = 4'h4;

	// Mode control register fields.
	localparam int MODE_REQ_LSB     = 0;
	localparam int SOFT_RESET_BIT   = 3;
	localparam int FAIL_RELEASE_BIT = 4;

	// Supply control register fields.
	localparam int BUS_WAKE_WD_EN_BIT = 0;
	localparam int KEEPON_BIT         = 1;
	localparam int STOP_KEEPON_BIT    = 2;
	localparam int OV_RST_EN_BIT      = 3;
	localparam int SECOND_EN_BIT      = 4;
	localparam int THIRD_EN_BIT       = 5;
	localparam logic [15:0] SUPPLY_CTRL_RESET = 16'h0001;
	localparam logic [15:0] SUPPLY_CTRL_MASK  = 16'h003F;

	// Flag positions; 0 to 15 read at STATUS_A, 16 to 31 at STATUS_B.
	localparam int F_POR       = 0;
	localparam int F_BAT_UV    = 1;
	localparam int F_HS_UV     = 2;
	localparam int F_HS_OV     = 3;
	localparam int F_WARN      = 4;
	localparam int F_MAIN_UV   = 5;
	localparam int F_UV_FS     = 6;
	localparam int F_MAIN_OV   = 7;
	localparam int F_SHORT     = 8;
	localparam int F_FAILURE   = 9;
	localparam int F_SECOND_UV = 10;
	localparam int F_CAN_UV    = 11;
	localparam int F_THERMAL   = 12;
	localparam int F_SECOND_OT = 13;
	localparam int F_THIRD_OT  = 14;
	localparam int F_HS_FAULT  = 16;
	localparam int F_LIN_ONE_FAIL_STATUS = 20;
	localparam int F_LIN_TWO_FAIL_STATUS = 22;
	localparam int F_CAN_FAIL  = 24;
	localparam int F_WAKE      = 26;
	localparam int F_WAKE_PIN  = 29;

	typedef enum logic [2:0] {
		MODE_INIT     = 3'h0,
		MODE_NORMAL   = 3'h1,
		MODE_STOP     = 3'h2,
		MODE_SLEEP    = 3'h3,
		MODE_RESTART  = 3'h4,
		MODE_FAILSAFE = 3'h5
	} mode_t;

	// Comparator, temperature detector, wake and strap levels from the analog side.
	typedef struct packed {
		logic       cfg_setting;
		logic       load_share;
		logic       battery_por_ok;
		logic       battery_uv;
		logic       highside_uv;
		logic       highside_ov;
		logic       main_warn;
		logic       main_uv;
		logic       main_ov;
		logic       second_reg_uv;
		logic       can_supply_uv;
		logic       ot_second_reg;
		logic       ot_third_reg;
		logic       ot_can;
		logic [1:0] ot_lin;
		logic [3:0] ot_highside;
		logic       wake_can;
		logic [1:0] wake_lin;
		logic       wake_pin;
	} sense_t;

endpackage

// file: logic/level_sync.sv
`timescale 1ns/1ns
module level_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input  wire logic             i_core_clk,
	input  wire logic             i_rst_n,
	// Asynchronous levels in, synchronised levels out.
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] stage;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stage  <= '0;
			o_sync <= '0;
		end else begin
			stage  <= i_async;
			o_sync <= stage;
		end
	end

endmodule // level_sync

// file: logic/supply_fault_supervisor.sv
`timescale 1ns/1ns
// How it works
// R01: Bus wake in stop mode restarts watchdog with long window when enable is set.
// R02: Bus-wake watchdog enable bit is writable only in normal mode.
// R03: Bus wake raises interrupt and pulls waking transceiver receive line low.
// R04: Host serves watchdog after long window; re-disable needs normal mode.
// R05: Power-on sets flag, loads defaults, holds reset until supply good and delay.
// R06: Battery below power-on level resets everything; restart in init mode.
// R07: Battery undervoltage flags, drops third regulator, suspends short protection.
// R08: High-side undervoltage disables LIN and sets its flag.
// R09: High-side overvoltage only sets its flag.
// R10: Main supply prewarning only sets the warning flag.
// R11: Main undervoltage pulls reset low, sets flag, enters restart; not in sleep.
// R12: Count undervoltage events in init, normal, stop; halt on battery low in normal.
// R13: Fourth undervoltage event enters fail-safe and sets its flag.
// R14: Counter clears on undervoltage fail-safe entry, flag clear, or soft reset.
// R15: Main overvoltage checked in init and normal; flag always set.
// R16: Overvoltage reset: restart and self-clear, or fail-safe, by configuration.
// R17: Host clears overvoltage reset enable before commanding stop mode.
// R18: Main supply low past short filter: short, failure, supply off, fail-safe.
// R19: Load sharing transistor off on battery low or in stop unless kept on.
// R20: Second regulator and CAN supply undervoltage flags are sticky; the second regulator flag is blanked at switching.
// R21: First-level overtemperature switches off the affected stage, sets thermal flag.
// R22: Hot regulators and high-side switches turn off and clear enables; the third keeps its enable under load sharing.
// R23: Hot transmitter disabled, receiver kept, fail status 01, auto re-enable.
// R24: Long open window lasts 200 ms.
// R25: All analog inputs pass a two-stage synchroniser first.
// R26: Flags clear by write only when their condition has gone.
module supply_fault_supervisor #(
	parameter int unsigned LONG_WINDOW_CYCLES  = sfs_pkg::LONG_WINDOW_CYCLES,
	parameter int unsigned RESET_DELAY_CYCLES  = sfs_pkg::RESET_DELAY_CYCLES,
	parameter int unsigned SHORT_FILTER_CYCLES = sfs_pkg::SHORT_FILTER_CYCLES
) (
	// Clock and reset.
	input  wire logic            i_core_clk,
	input  wire logic            i_rst_n,
	// Analog comparators, temperature detectors, wake inputs and straps.
	input  wire sfs_pkg::sense_t i_sense,
	// Register port.
	input  wire logic [3:0]      i_addr,
	input  wire logic [15:0]     i_wdata,
	input  wire logic            i_wr,
	input  wire logic            i_rd,
	output logic [15:0]          o_rdata,
	// Mode, reset output, fail outputs, watchdog start and long window.
	output sfs_pkg::mode_t       o_mode,
	output logic                 o_reset_output_n,
	output logic                 o_fail_outputs,
	output logic                 o_watchdog_restart,
	output logic                 o_long_window,
	// Supply enables.
	output logic                 o_main_supply_en,
	output logic                 o_second_reg_en,
	output logic                 o_third_reg_en,
	output logic [3:0]           o_highside_en,
	// Transceivers and wake signalling.
	output logic [1:0]           o_lin_tx_en,
	output logic [1:0]           o_lin_rx_en,
	output logic                 o_can_tx_en,
	output logic [2:0]           o_rxd_wake_low,
	output logic                 o_wake_int
);

	sfs_pkg::sense_t s;
	sfs_pkg::sense_t p;
	sfs_pkg::mode_t  mode;
	sfs_pkg::mode_t  next_mode;
	sfs_pkg::mode_t  req_mode;

	logic        reset_out;
	logic        main_en;
	logic        lw_active;
	logic [15:0] supply_ctrl;
	logic [3:0]  hs_ctrl;
	logic        second_en_d;
	logic [15:0] settle_cnt;
	logic [2:0]  uv_cnt;
	logic [31:0] rd_cnt;
	logic [31:0] sc_cnt;
	logic [31:0] lw_cnt;
	logic [31:0] flag;
	logic [31:0] set;
	logic [31:0] cond;
	logic [31:0] clr;

	logic       por_lost;
	logic       por_rise;
	logic       powered;
	logic       supplied;
	logic       uv_event;
	logic       uv_count;
	logic       uv_fs_trip;
	logic       uv_clear;
	logic       ov_trip;
	logic       ov_act;
	logic       short_run;
	logic       short_trip;
	logic       release_now;
	logic [2:0] bus_wake_rise;
	logic       pin_wake_rise;
	logic       any_wake;
	logic       bus_wake;
	logic       wd_start;
	logic       ctrl_wr;
	logic       host_mode;
	logic       soft_reset;
	logic       supply_wr;
	logic       hs_wr;
	logic       hs_ot;
	logic       second_ot;
	logic       third_ot;

	level_sync #(
		.WIDTH($bits(sfs_pkg::sense_t))
	) u_sense_sync (
		.i_core_clk(i_core_clk),
		.i_rst_n   (i_rst_n),
		.i_async   (i_sense),
		.o_sync    (s)
	); // R25

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			p <= '0;
		end else begin
			p <= s;
		end
	end

	assign por_lost      = !s.battery_por_ok;
	assign por_rise      = s.battery_por_ok & !p.battery_por_ok;
	assign powered       = (mode == sfs_pkg::MODE_INIT) | (mode == sfs_pkg::MODE_NORMAL) | (mode == sfs_pkg::MODE_STOP);
	assign supplied      = main_en & (mode != sfs_pkg::MODE_SLEEP) & (mode != sfs_pkg::MODE_FAILSAFE);
	assign bus_wake_rise = {s.wake_lin & ~p.wake_lin, s.wake_can & !p.wake_can};
	assign pin_wake_rise = s.wake_pin & !p.wake_pin;
	assign any_wake      = (|bus_wake_rise) | pin_wake_rise;
	assign req_mode      = sfs_pkg::mode_t'(i_wdata[sfs_pkg::MODE_REQ_LSB +: 3]);
	assign ctrl_wr       = i_wr & (i_addr == sfs_pkg::REG_CTRL_MODE);
	assign supply_wr     = i_wr & (i_addr == sfs_pkg::REG_SUPPLY_CTRL);
	assign hs_wr         = i_wr & (i_addr == sfs_pkg::REG_HS_CTRL);
	assign host_mode     = ctrl_wr & powered;
	assign soft_reset    = ctrl_wr & i_wdata[sfs_pkg::SOFT_RESET_BIT]
		& ((mode == sfs_pkg::MODE_NORMAL) | (mode == sfs_pkg::MODE_STOP));

	// Undervoltage is only seen while the main supply is meant to be up.
	assign uv_event   = s.main_uv & !p.main_uv & supplied; // R11
	assign uv_count   = uv_event & powered & !((mode == sfs_pkg::MODE_NORMAL) & s.battery_uv); // R12
	assign uv_fs_trip = uv_count & (uv_cnt == sfs_pkg::UV_FAILSAFE_COUNT - 3'h1); // R13
	assign uv_clear   = clr[sfs_pkg::F_MAIN_UV] & !cond[sfs_pkg::F_MAIN_UV] & !set[sfs_pkg::F_MAIN_UV];

	assign ov_trip = s.main_ov & !p.main_ov & ((mode == sfs_pkg::MODE_INIT) | (mode == sfs_pkg::MODE_NORMAL)); // R15
	assign ov_act  = ov_trip & supply_ctrl[sfs_pkg::OV_RST_EN_BIT]; // R16

	// Short protection rests while the battery is under its undervoltage level.
	assign short_run  = s.main_uv & supplied & !s.battery_uv; // R07
	assign short_trip = short_run & (sc_cnt == SHORT_FILTER_CYCLES - 1); // R18

	assign release_now = !reset_out & main_en & !s.main_uv
		& ((mode == sfs_pkg::MODE_INIT) | (mode == sfs_pkg::MODE_RESTART))
		& (rd_cnt == RESET_DELAY_CYCLES - 1); // R05

	assign bus_wake = (mode == sfs_pkg::MODE_STOP) & supply_ctrl[sfs_pkg::BUS_WAKE_WD_EN_BIT] & (|bus_wake_rise); // R01
	assign wd_start = release_now | bus_wake | ((mode == sfs_pkg::MODE_STOP) & (next_mode == sfs_pkg::MODE_NORMAL));

	// Thermal shutdown acts only on stages that are switched on.
	assign second_ot = s.ot_second_reg & supply_ctrl[sfs_pkg::SECOND_EN_BIT];
	assign third_ot  = s.ot_third_reg & supply_ctrl[sfs_pkg::THIRD_EN_BIT];
	assign hs_ot     = |(s.ot_highside & hs_ctrl);

	always_comb begin
		next_mode = mode;
		if (por_lost) begin
			next_mode = sfs_pkg::MODE_INIT; // R06
		end else if (short_trip | uv_fs_trip) begin
			next_mode = sfs_pkg::MODE_FAILSAFE; // R13 R18
		end else if (ov_act) begin
			next_mode = s.cfg_setting ? sfs_pkg::MODE_RESTART : sfs_pkg::MODE_FAILSAFE; // R16
		end else if (uv_event) begin
			next_mode = sfs_pkg::MODE_RESTART; // R11
		end else begin
			case (mode)
				sfs_pkg::MODE_RESTART: begin
					if (release_now) begin
						next_mode = sfs_pkg::MODE_NORMAL;
					end
				end
				sfs_pkg::MODE_SLEEP, sfs_pkg::MODE_FAILSAFE: begin
					if (any_wake) begin
						next_mode = sfs_pkg::MODE_RESTART; // R18
					end
				end
				default: begin
					if (host_mode & ((req_mode == sfs_pkg::MODE_NORMAL) | (req_mode == sfs_pkg::MODE_STOP)
						| (req_mode == sfs_pkg::MODE_SLEEP))) begin
						next_mode = req_mode;
					end
				end
			endcase
		end
	end

	// Mode and reset output.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode      <= sfs_pkg::MODE_INIT;
			reset_out <= 1'b0;
		end else begin
			mode <= next_mode;
			if (por_lost | (next_mode == sfs_pkg::MODE_RESTART) | (next_mode == sfs_pkg::MODE_FAILSAFE)
				| (next_mode == sfs_pkg::MODE_SLEEP)) begin
				reset_out <= 1'b0; // R11
			end else if (release_now) begin
				reset_out <= 1'b1; // R05
			end
		end
	end

	// Main supply switch.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			main_en <= 1'b1;
		end else if (por_lost) begin
			main_en <= 1'b1;
		end else if (short_trip | (next_mode == sfs_pkg::MODE_SLEEP)) begin
			main_en <= 1'b0; // R18
		end else if (((mode == sfs_pkg::MODE_SLEEP) | (mode == sfs_pkg::MODE_FAILSAFE)) & any_wake) begin
			main_en <= 1'b1;
		end
	end

	// Fail outputs stay active until the host releases them in normal mode.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_fail_outputs <= 1'b0;
		end else if (por_lost) begin
			o_fail_outputs <= 1'b0;
		end else if (short_trip | ov_act) begin
			o_fail_outputs <= 1'b1; // R16 R18
		end else if (ctrl_wr & i_wdata[sfs_pkg::FAIL_RELEASE_BIT] & (mode == sfs_pkg::MODE_NORMAL)) begin
			o_fail_outputs <= 1'b0;
		end
	end

	// Reset delay and short filter timers.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_cnt <= 32'h0;
			sc_cnt <= 32'h0;
		end else begin
			if (!reset_out & main_en & !s.main_uv & !release_now & !por_lost
				& ((mode == sfs_pkg::MODE_INIT) | (mode == sfs_pkg::MODE_RESTART))) begin
				rd_cnt <= rd_cnt + 32'h1;
			end else begin
				rd_cnt <= 32'h0;
			end
			if (short_run & !short_trip & !por_lost) begin
				sc_cnt <= sc_cnt + 32'h1;
			end else begin
				sc_cnt <= 32'h0;
			end
		end
	end

	// Long open window of the watchdog.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lw_cnt             <= 32'h0;
			lw_active          <= 1'b0;
			o_watchdog_restart <= 1'b0;
		end else begin
			o_watchdog_restart <= wd_start & !por_lost; // R01
			if (por_lost) begin
				lw_cnt    <= 32'h0;
				lw_active <= 1'b0;
			end else if (wd_start) begin
				lw_cnt    <= 32'h0;
				lw_active <= 1'b1;
			end else if (lw_active) begin
				if (lw_cnt == LONG_WINDOW_CYCLES - 1) begin
					lw_active <= 1'b0; // R24
				end else begin
					lw_cnt <= lw_cnt + 32'h1;
				end
			end
		end
	end

	// Undervoltage event counter.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			uv_cnt <= 3'h0;
		end else if (por_lost | uv_fs_trip | uv_clear | soft_reset) begin
			uv_cnt <= 3'h0; // R14
		end else if (uv_count) begin
			uv_cnt <= uv_cnt + 3'h1; // R12
		end
	end

	// Supply control register; hardware clears win over a write in the same cycle.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			supply_ctrl <= sfs_pkg::SUPPLY_CTRL_RESET;
		end else if (por_lost | soft_reset) begin
			supply_ctrl <= sfs_pkg::SUPPLY_CTRL_RESET; // R05
		end else begin
			if (supply_wr) begin
				supply_ctrl <= i_wdata & sfs_pkg::SUPPLY_CTRL_MASK;
				if (mode != sfs_pkg::MODE_NORMAL) begin
					supply_ctrl[sfs_pkg::BUS_WAKE_WD_EN_BIT] <= supply_ctrl[sfs_pkg::BUS_WAKE_WD_EN_BIT]; // R02
				end
			end
			if (ov_act & s.cfg_setting) begin
				supply_ctrl[sfs_pkg::OV_RST_EN_BIT] <= 1'b0; // R16
			end
			if (second_ot) begin
				supply_ctrl[sfs_pkg::SECOND_EN_BIT] <= 1'b0; // R22
			end
			if (third_ot & !s.load_share) begin
				supply_ctrl[sfs_pkg::THIRD_EN_BIT] <= 1'b0; // R22
			end
		end
	end

	// High-side control; any hot switch that is switched on turns all of them off.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hs_ctrl <= 4'h0;
		end else if (por_lost | soft_reset | hs_ot) begin
			hs_ctrl <= 4'h0; // R22
		end else if (hs_wr) begin
			hs_ctrl <= i_wdata[3:0];
		end
	end

	// Blanking of the second regulator undervoltage flag around switching.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			second_en_d <= 1'b0;
			settle_cnt  <= 16'h0;
		end else begin
			second_en_d <= supply_ctrl[sfs_pkg::SECOND_EN_BIT];
			if (second_en_d != supply_ctrl[sfs_pkg::SECOND_EN_BIT]) begin
				settle_cnt <= 16'h0;
			end else if (settle_cnt != sfs_pkg::SECOND_SETTLE_CYCLES) begin
				settle_cnt <= settle_cnt + 16'h1;
			end
		end
	end

	always_comb begin
		set                           = '0;
		set[sfs_pkg::F_POR]           = por_rise; // R05
		set[sfs_pkg::F_BAT_UV]        = s.battery_uv; // R07
		set[sfs_pkg::F_HS_UV]         = s.highside_uv; // R08
		set[sfs_pkg::F_HS_OV]         = s.highside_ov; // R09
		set[sfs_pkg::F_WARN]          = s.main_warn & supplied; // R10
		set[sfs_pkg::F_MAIN_UV]       = uv_event; // R11
		set[sfs_pkg::F_UV_FS]         = uv_fs_trip; // R13
		set[sfs_pkg::F_MAIN_OV]       = ov_trip; // R15
		set[sfs_pkg::F_SHORT]         = short_trip; // R18
		set[sfs_pkg::F_FAILURE]       = short_trip; // R18
		set[sfs_pkg::F_SECOND_UV]     = s.second_reg_uv & supply_ctrl[sfs_pkg::SECOND_EN_BIT]
			& second_en_d & (settle_cnt == sfs_pkg::SECOND_SETTLE_CYCLES); // R20
		set[sfs_pkg::F_CAN_UV]        = s.can_supply_uv; // R20
		set[sfs_pkg::F_THERMAL]       = second_ot | third_ot | hs_ot | s.ot_can | (|s.ot_lin); // R21
		set[sfs_pkg::F_SECOND_OT]     = second_ot; // R22
		set[sfs_pkg::F_THIRD_OT]      = third_ot; // R22
		set[sfs_pkg::F_HS_FAULT +: 4] = s.ot_highside & {4{hs_ot}}; // R22
		set[sfs_pkg::F_LIN_ONE_FAIL_STATUS]     = s.ot_lin[0]; // R23
		set[sfs_pkg::F_LIN_TWO_FAIL_STATUS]     = s.ot_lin[1]; // R23
		set[sfs_pkg::F_CAN_FAIL]      = s.ot_can; // R23
		set[sfs_pkg::F_WAKE +: 3]     = bus_wake_rise; // R03
		set[sfs_pkg::F_WAKE_PIN]      = pin_wake_rise;
	end

	always_comb begin
		cond                           = '0;
		cond[sfs_pkg::F_BAT_UV]        = s.battery_uv;
		cond[sfs_pkg::F_HS_UV]         = s.highside_uv;
		cond[sfs_pkg::F_HS_OV]         = s.highside_ov;
		cond[sfs_pkg::F_WARN]          = s.main_warn;
		cond[sfs_pkg::F_MAIN_UV]       = s.main_uv;
		cond[sfs_pkg::F_MAIN_OV]       = s.main_ov;
		cond[sfs_pkg::F_SECOND_UV]     = s.second_reg_uv;
		cond[sfs_pkg::F_CAN_UV]        = s.can_supply_uv;
		cond[sfs_pkg::F_THERMAL]       = s.ot_second_reg | s.ot_third_reg | s.ot_can | (|s.ot_lin) | (|s.ot_highside);
		cond[sfs_pkg::F_SECOND_OT]     = s.ot_second_reg;
		cond[sfs_pkg::F_THIRD_OT]      = s.ot_third_reg;
		cond[sfs_pkg::F_HS_FAULT +: 4] = s.ot_highside;
		cond[sfs_pkg::F_LIN_ONE_FAIL_STATUS]     = s.ot_lin[0];
		cond[sfs_pkg::F_LIN_TWO_FAIL_STATUS]     = s.ot_lin[1];
		cond[sfs_pkg::F_CAN_FAIL]      = s.ot_can;
	end

	always_comb begin
		clr = '0;
		if (i_wr & (i_addr == sfs_pkg::REG_STATUS_A)) begin
			clr[15:0] = i_wdata;
		end else if (i_wr & (i_addr == sfs_pkg::REG_STATUS_B)) begin
			clr[31:16] = i_wdata;
		end
	end

	// A set in the clearing cycle wins; a clear while the cause persists is ignored.
	for (genvar b = 0; b < 32; b++) begin : g_flag
		always_ff @(posedge i_core_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				flag[b] <= 1'b0;
			end else if (por_lost) begin
				flag[b] <= 1'b0;
			end else begin
				flag[b] <= set[b] | (flag[b] & !(clr[b] & !cond[b])); // R26
			end
		end
	end

	// Supply and transceiver enables, wake signalling.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_second_reg_en <= 1'b0;
			o_third_reg_en  <= 1'b0;
			o_highside_en   <= 4'h0;
			o_lin_tx_en     <= 2'h0;
			o_lin_rx_en     <= 2'h0;
			o_can_tx_en     <= 1'b0;
			o_rxd_wake_low  <= 3'h0;
			o_wake_int      <= 1'b0;
		end else begin
			o_second_reg_en <= supply_ctrl[sfs_pkg::SECOND_EN_BIT];
			o_third_reg_en  <= supply_ctrl[sfs_pkg::THIRD_EN_BIT]
				& !(s.battery_uv & !supply_ctrl[sfs_pkg::KEEPON_BIT]) // R07 R19
				& !(s.load_share & (mode == sfs_pkg::MODE_STOP) & !supply_ctrl[sfs_pkg::STOP_KEEPON_BIT]) // R19
				& !(s.load_share & s.ot_third_reg); // R21
			o_highside_en   <= hs_ctrl;
			o_lin_tx_en     <= {2{!s.highside_uv}} & ~s.ot_lin; // R08 R23
			o_lin_rx_en     <= {2{!s.highside_uv}}; // R08
			o_can_tx_en     <= !s.ot_can; // R23
			o_rxd_wake_low  <= flag[sfs_pkg::F_WAKE +: 3]; // R03
			o_wake_int      <= |flag[sfs_pkg::F_WAKE +: 4]; // R03
		end
	end

	// Read data stand for one cycle after the read strobe.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= 16'h0;
		end else if (!i_rd) begin
			o_rdata <= 16'h0;
		end else if (i_addr == sfs_pkg::REG_CTRL_MODE) begin
			o_rdata <= {11'h0, o_fail_outputs, 1'b0, mode};
		end else if (i_addr == sfs_pkg::REG_SUPPLY_CTRL) begin
			o_rdata <= supply_ctrl;
		end else if (i_addr == sfs_pkg::REG_HS_CTRL) begin
			o_rdata <= {12'h0, hs_ctrl};
		end else if (i_addr == sfs_pkg::REG_STATUS_A) begin
			o_rdata <= flag[15:0];
		end else if (i_addr == sfs_pkg::REG_STATUS_B) begin
			o_rdata <= flag[31:16];
		end else begin
			o_rdata <= 16'h0;
		end
	end

	assign o_mode           = mode;
	assign o_reset_output_n = reset_out;
	assign o_long_window    = lw_active;
	assign o_main_supply_en = main_en;

endmodule // supply_fault_supervisor

// file: tb/supply_fault_supervisor_properties.sv
`timescale 1ns/1ns
module sfs_checker (
	// Clock and reset.
	input wire logic            i_core_clk,
	input wire logic            i_rst_n,
	// Watched ports.
	input wire sfs_pkg::sense_t i_sense,
	input wire sfs_pkg::mode_t  o_mode,
	input wire logic            o_reset_output_n,
	input wire logic            o_watchdog_restart,
	input wire logic            o_long_window,
	input wire logic [3:0]      o_highside_en,
	input wire logic [1:0]      o_lin_tx_en,
	input wire logic [1:0]      o_lin_rx_en,
	input wire logic            o_can_tx_en,
	input wire logic [2:0]      o_rxd_wake_low,
	input wire logic            o_wake_int
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	property p_uv;
		$rose(i_sense.main_uv) && o_mode == sfs_pkg::MODE_NORMAL |-> ##[1:6] !o_reset_output_n;
	endproperty
	a_uv: assert property (p_uv) else $error("undervoltage kept reset high");
	property p_win;
		o_watchdog_restart |=> o_long_window[*8];
	endproperty
	a_win: assert property (p_win) else $error("long window too short");
	property p_hsuv;
		i_sense.highside_uv[*8] |-> o_lin_tx_en == 2'h0 && o_lin_rx_en == 2'h0;
	endproperty
	a_hsuv: assert property (p_hsuv) else $error("lin left on");
	property p_canot;
		i_sense.ot_can[*8] |-> !o_can_tx_en;
	endproperty
	a_canot: assert property (p_canot) else $error("hot can transmitter on");
	property p_hsot;
		(i_sense.ot_highside != 4'h0)[*8] |-> o_highside_en == 4'h0;
	endproperty
	a_hsot: assert property (p_hsot) else $error("hot high side on");
	property p_por;
		!i_sense.battery_por_ok[*8] |-> o_mode == sfs_pkg::MODE_INIT && !o_reset_output_n;
	endproperty
	a_por: assert property (p_por) else $error("no reset on power loss");
	property p_wake;
		$rose(|o_rxd_wake_low) |-> ##[0:2] o_wake_int;
	endproperty
	a_wake: assert property (p_wake) else $error("wake without interrupt");
	property p_rel;
		$rose(o_reset_output_n) |-> !$past(i_sense.main_uv, 6);
	endproperty
	a_rel: assert property (p_rel) else $error("reset released on low supply");
endmodule // sfs_checker

bind supply_fault_supervisor sfs_checker u_checker (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_sense(i_sense),
	.o_mode(o_mode), .o_reset_output_n(o_reset_output_n), .o_watchdog_restart(o_watchdog_restart),
	.o_long_window(o_long_window), .o_highside_en(o_highside_en), .o_lin_tx_en(o_lin_tx_en),
	.o_lin_rx_en(o_lin_rx_en), .o_can_tx_en(o_can_tx_en), .o_rxd_wake_low(o_rxd_wake_low), .o_wake_int(o_wake_int));

// file: tb/supply_sense_model.sv
`timescale 1ns/1ns
module supply_sense_model (
	// Clock.
	input  wire logic      i_core_clk,
	// Levels seen by the supervisor.
	output sfs_pkg::sense_t o_sense
);
	sfs_pkg::sense_t want = '{cfg_setting: 1'b1, battery_por_ok: 1'b1, default: '0};
	// Levels move only on a rising edge, as a clean comparator would.
	always @(posedge i_core_clk) o_sense <= want;
endmodule // supply_sense_model

// file: tb/supply_fault_supervisor_bench.sv
`timescale 1ns/1ns
module supply_fault_supervisor_bench;
	logic            clk = 0;
	logic            rst_n = 0;
	logic            wr = 0;
	logic            rd = 0;
	logic [3:0]      addr = 4'h0;
	logic [15:0]     wdata = 16'h0000;
	logic [15:0]     rdata;
	logic [15:0]     got;
	logic            rst_out_n;
	logic            wd_restart;
	logic            wake_int;
	logic            can_tx;
	logic [2:0]      rxd_low;
	sfs_pkg::sense_t sense;
	sfs_pkg::mode_t  mode;
	int              mismatches = 0;
	int              checked = 0;
	int              i;
	always #2 clk = ~clk;
	supply_sense_model u_sense (.i_core_clk(clk), .o_sense(sense));
	supply_fault_supervisor #(.LONG_WINDOW_CYCLES(50), .RESET_DELAY_CYCLES(20), .SHORT_FILTER_CYCLES(40)) u_dut (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_sense(sense), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .o_mode(mode), .o_reset_output_n(rst_out_n), .o_fail_outputs(), .o_watchdog_restart(wd_restart),
		.o_long_window(), .o_main_supply_en(), .o_second_reg_en(), .o_third_reg_en(), .o_highside_en(), .o_lin_tx_en(),
		.o_lin_rx_en(), .o_can_tx_en(can_tx), .o_rxd_wake_low(rxd_low), .o_wake_int(wake_int));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic write(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic read(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		got = rdata;
	endtask
	// Waits for the watchdog pulse (sel 1) or the reset release (sel 0) on falling edges.
	task automatic await(input bit sel);
		for (int n = 0; n < 400 && (sel ? wd_restart : rst_out_n) !== 1'b1; n++) @(negedge clk);
		check(16'((sel ? wd_restart : rst_out_n) === 1'b1), 16'h0001);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#16000;
		mismatches++;
		wrap_up();
	end
	initial begin
		idle(10);
		rst_n <= 1'b1;
		await(0);
		read(sfs_pkg::REG_STATUS_A);
		check(got, 16'h0001);
		write(sfs_pkg::REG_SUPPLY_CTRL, 16'h0000);
		read(sfs_pkg::REG_SUPPLY_CTRL);
		check(got, sfs_pkg::SUPPLY_CTRL_RESET);
		write(sfs_pkg::REG_CTRL_MODE, 16'h0001);
		$display("test power_up done");
		u_sense.want.main_warn = 1'b1;
		u_sense.want.highside_uv = 1'b1;
		u_sense.want.highside_ov = 1'b1;
		idle(6);
		write(sfs_pkg::REG_STATUS_A, 16'h001C);
		read(sfs_pkg::REG_STATUS_A);
		check(got, 16'h001D);
		u_sense.want.main_warn = 1'b0;
		u_sense.want.highside_uv = 1'b0;
		u_sense.want.highside_ov = 1'b0;
		idle(6);
		write(sfs_pkg::REG_STATUS_A, 16'h001D);
		read(sfs_pkg::REG_STATUS_A);
		check(got, 16'h0000);
		$display("test supply_flags done");
		write(sfs_pkg::REG_HS_CTRL, 16'h000F);
		u_sense.want.ot_can = 1'b1;
		u_sense.want.ot_lin = 2'h3;
		u_sense.want.ot_highside = 4'h1;
		idle(6);
		check(16'(can_tx), 16'h0000);
		read(sfs_pkg::REG_STATUS_B);
		check(got & 16'h03F1, 16'h0151);
		read(sfs_pkg::REG_STATUS_A);
		check(got & 16'h1000, 16'h1000);
		u_sense.want.ot_can = 1'b0;
		u_sense.want.ot_lin = 2'h0;
		u_sense.want.ot_highside = 4'h0;
		idle(6);
		check(16'(can_tx), 16'h0001);
		$display("test thermal done");
		write(sfs_pkg::REG_CTRL_MODE, 16'h0002);
		u_sense.want.wake_can = 1'b1;
		await(1);
		idle(2);
		check({13'h0000, rxd_low}, 16'h0001);
		check(16'(wake_int), 16'h0001);
		u_sense.want.wake_can = 1'b0;
		write(sfs_pkg::REG_CTRL_MODE, 16'h0001);
		$display("test bus_wake done");
		for (i = 0; i < 4; i++) begin
			u_sense.want.main_uv = 1'b1;
			idle(6);
			check(16'(mode), i < 3 ? 16'h0004 : 16'h0005);
			u_sense.want.main_uv = 1'b0;
			if (i < 3) await(0);
		end
		read(sfs_pkg::REG_STATUS_A);
		check(got & 16'h0060, 16'h0060);
		$display("test undervoltage done");
		u_sense.want.battery_por_ok = 1'b0;
		idle(6);
		check({12'h000, mode, rst_out_n}, 16'h0000);
		u_sense.want.battery_por_ok = 1'b1;
		await(0);
		read(sfs_pkg::REG_STATUS_A);
		check(got, 16'h0001);
		$display("test power_loss done");
		wrap_up();
	end
endmodule // supply_fault_supervisor_bench
